/* src/fae_pkg.sv */
/*
  Shared constants and types of the flash access error monitor: register
  addresses, bit positions, reset values, address ranges and command kinds.
  Assumes nothing of its surroundings; imported by the range checker and the monitor, not by sticky_flag.
*/
package fae_pkg;

    // register byte addresses on the peripheral bus
    localparam logic [31:0] STATUS_ADDR = 32'hFFA1_0010;
    localparam logic [31:0] ENABLE_ADDR = 32'hFFA1_0014;

    // bit positions shared by status and enable registers
    localparam int unsigned BIT_CODE = 7;
    localparam int unsigned BIT_LOCK = 4;
    localparam int unsigned BIT_DATA = 3;
    localparam int unsigned BIT_CORR = 0;

    // reset values and writable bits
    localparam logic [7:0] ENABLE_RESET = 8'h99;
    localparam logic [7:0] ENABLE_WMASK = 8'h99;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // start address bits 18..0 checked in data flash mode
    localparam int unsigned ADDR_W = 19;
    localparam logic [18:0] AREA_LO = 19'h0_0000;
    localparam logic [18:0] AREA_HI = 19'h7_FFFF;
    localparam logic [18:0] DATA_RSV_LO = 19'h1_0000;
    localparam logic [18:0] SETUP_LOW_HI = 19'h0_003F;
    localparam logic [18:0] CFG_RSV_LO = 19'h0_0100;
    localparam logic [18:0] OTP_RSV_LO = 19'h0_00A0;

    // kind of command the sequencer is issuing
    typedef enum logic [1:0] {
        CMD_OTHER,
        CMD_CONFIG_PROGRAM,
        CMD_OTP_SET
    } cmd_kind_t;

    // command lock state of the sequencer
    typedef enum logic {
        UNLOCKED,
        LOCKED
    } lock_state_t;

endpackage

/* src/address_range_checker.sv */
/*
  Combinational check of a command start address against the reserved
  ranges of the data flash area.
  Assumes the kind and address are stable while issue is high.
*/
`timescale 1ns/1ps
`default_nettype none
module address_range_checker
(
    input wire logic data_flash_pe_mode,
    input wire fae_pkg::cmd_kind_t cmd_kind,
    input wire logic [18:0] command_start_address,
    output logic data_area_violation
);
    import fae_pkg::*;

    // inclusive window test, used for every range below
    function automatic logic in_range(input logic [18:0] a,
                                      input logic [18:0] lo,
                                      input logic [18:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // reserved data area applies to every command; setup commands add more
    always_comb
    begin
        data_area_violation = 1'b0;
        if (data_flash_pe_mode)
        begin
            if (in_range(command_start_address, DATA_RSV_LO, AREA_HI))
                data_area_violation = 1'b1;
            case (cmd_kind)
                CMD_CONFIG_PROGRAM:
                    if (in_range(command_start_address, AREA_LO, SETUP_LOW_HI)
                        || in_range(command_start_address, CFG_RSV_LO,
                                    AREA_HI))
                        data_area_violation = 1'b1;
                CMD_OTP_SET:
                    if (in_range(command_start_address, AREA_LO, SETUP_LOW_HI)
                        || in_range(command_start_address, OTP_RSV_LO,
                                    AREA_HI))
                        data_area_violation = 1'b1;
                default:
                    ;
            endcase
        end
    end
endmodule
`default_nettype wire

/* src/sticky_flag.sv */
/*
  One sticky status bit: set by hardware, cleared by hardware or, when
  enabled, by software writing 0 after having read the bit as 1.
  Assumes a read and a write of the bit never fall in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module sticky_flag
#(
    parameter bit SW_CLEAR = 1'b1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic set,
    input wire logic hw_clear,
    input wire logic sw_read_one,
    input wire logic sw_write,
    input wire logic sw_wdata,
    output logic flag
);
    logic flag_q;
    logic flag_d;
    logic armed_q;
    logic armed_d;

    // software clear needs a prior read of 1; a set in the same cycle wins
    always_comb
    begin
        armed_d = armed_q;
        flag_d = flag_q;
        if (sw_write)
            armed_d = 1'b0;
        else if (sw_read_one)
            armed_d = 1'b1;
        if (hw_clear)
            flag_d = 1'b0;
        if (SW_CLEAR && sw_write && !sw_wdata && armed_q)
            flag_d = 1'b0;
        if (set)
            flag_d = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_q <= 1'b0;
            armed_q <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
            armed_q <= armed_d;
        end
    end

    assign flag = flag_q;
endmodule
`default_nettype wire

/* src/flash_access_error_monitor.sv */
/*
  Access error status and interrupt enable registers of the flash
  sequencer, reached over APB, with the flash error interrupt line.
  Assumes the sequencer gives one-cycle event pulses synchronous to pclk
  and holds command kind and start address valid with cmd_issue.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_access_error_monitor
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmd_issue,
    input wire fae_pkg::cmd_kind_t cmd_kind,
    input wire logic data_flash_pe_mode,
    input wire logic [31:0] command_start_address,
    input wire logic code_area_error_detect,
    input wire logic lock_error_detect,
    input wire logic corrected_read,
    input wire logic status_clear_start,
    input wire logic config_read_corrected,
    input wire logic parameter_table_corrected,
    input wire logic one_time_area_corrected,
    output logic illegal_operation_error,
    output logic command_locked,
    output logic flash_error_interrupt
);
    import fae_pkg::*;

    // register address decode, used for reads, writes and errors
    function automatic logic reg_hit(input logic [31:0] a,
                                     input logic [31:0] target);
        reg_hit = (a == target);
    endfunction

    logic setup_phase;
    logic access_rd;
    logic access_wr;
    logic hit_status;
    logic hit_enable;
    logic byte0_wr;
    logic data_area_violation;
    logic data_set;
    logic code_set;
    logic lock_set;
    logic lock_release;
    logic corr_clear;
    logic code_area_access_error;
    logic data_area_access_error;
    logic single_bit_corrected;
    logic status_wr;
    logic [7:0] status_view;
    logic [7:0] enable_q;
    logic [7:0] enable_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    lock_state_t lock_q;
    lock_state_t lock_d;
    logic illegal_q;
    logic illegal_d;
    logic irq_q;
    logic irq_d;

    // bus phases; the slave never stalls so every access ends in one cycle
    assign setup_phase = psel && !penable;
    assign access_rd = psel && penable && !pwrite;
    assign access_wr = psel && penable && pwrite;
    assign hit_status = reg_hit(paddr, STATUS_ADDR);
    assign hit_enable = reg_hit(paddr, ENABLE_ADDR);
    assign byte0_wr = access_wr && pstrb[0];
    assign status_wr = byte0_wr && hit_status;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(hit_status || hit_enable);

    address_range_checker u_range
    (
        .data_flash_pe_mode(data_flash_pe_mode),
        .cmd_kind(cmd_kind),
        .command_start_address(command_start_address[ADDR_W-1:0]),
        .data_area_violation(data_area_violation)
    );

    // event sources feeding the sticky flags
    assign data_set = cmd_issue && data_area_violation;
    assign code_set = code_area_error_detect;
    assign lock_set = lock_error_detect || data_set || code_set;
    assign corr_clear = status_clear_start && config_read_corrected
                        && parameter_table_corrected
                        && one_time_area_corrected;

    // read arming uses what software actually saw in prdata
    sticky_flag #(.SW_CLEAR(1'b1)) u_code_flag
    (
        .pclk(pclk),
        .presetn(presetn),
        .set(code_set),
        .hw_clear(1'b0),
        .sw_read_one(access_rd && hit_status && prdata_q[BIT_CODE]),
        .sw_write(status_wr),
        .sw_wdata(pwdata[BIT_CODE]),
        .flag(code_area_access_error)
    );

    sticky_flag #(.SW_CLEAR(1'b1)) u_data_flag
    (
        .pclk(pclk),
        .presetn(presetn),
        .set(data_set),
        .hw_clear(1'b0),
        .sw_read_one(access_rd && hit_status && prdata_q[BIT_DATA]),
        .sw_write(status_wr),
        .sw_wdata(pwdata[BIT_DATA]),
        .flag(data_area_access_error)
    );

    // correction bit is cleared only by the sequencer, never by software
    sticky_flag #(.SW_CLEAR(1'b0)) u_corr_flag
    (
        .pclk(pclk),
        .presetn(presetn),
        .set(corrected_read),
        .hw_clear(corr_clear),
        .sw_read_one(1'b0),
        .sw_write(1'b0),
        .sw_wdata(1'b0),
        .flag(single_bit_corrected)
    );

    // release needs both area errors already 0; a new lock event wins
    assign lock_release = status_clear_start && !code_area_access_error
                          && !data_area_access_error;

    always_comb
    begin
        lock_d = lock_q;
        case (lock_q)
            UNLOCKED:
                if (lock_set)
                    lock_d = LOCKED;
            LOCKED:
                if (lock_release && !lock_set)
                    lock_d = UNLOCKED;
            default:
                lock_d = UNLOCKED;
        endcase
    end

    // status view; reserved bits are tied low
    always_comb
    begin
        status_view = STATUS_RESET;
        status_view[BIT_CODE] = code_area_access_error;
        status_view[BIT_LOCK] = (lock_q == LOCKED);
        status_view[BIT_DATA] = data_area_access_error;
        status_view[BIT_CORR] = single_bit_corrected;
    end

    // enable register: byte lane 0 only, reserved bits never stored
    always_comb
    begin
        enable_d = enable_q;
        if (byte0_wr && hit_enable)
            enable_d = pwdata[7:0] & ENABLE_WMASK;
    end

    // read data captured in setup so prdata comes from a flop
    always_comb
    begin
        prdata_d = prdata_q;
        if (setup_phase)
        begin
            prdata_d = 32'h0000_0000;
            if (hit_status)
                prdata_d[7:0] = status_view;
            else if (hit_enable)
                prdata_d[7:0] = enable_q;
        end
    end

    // pulse only on the 0 to 1 step of the data error flag
    assign illegal_d = data_set && !data_area_access_error;

    // gated OR of flags, registered so the error line is glitch free
    assign irq_d = |(status_view & enable_q);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_q <= UNLOCKED;
            enable_q <= ENABLE_RESET;
            prdata_q <= 32'h0000_0000;
            illegal_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            lock_q <= lock_d;
            enable_q <= enable_d;
            prdata_q <= prdata_d;
            illegal_q <= illegal_d;
            irq_q <= irq_d;
        end
    end

    assign prdata = prdata_q;
    assign illegal_operation_error = illegal_q;
    assign command_locked = (lock_q == LOCKED);
    assign flash_error_interrupt = irq_q;

    // checks
    property p_reserved_data_area;
        @(posedge pclk) disable iff (!presetn)
        (cmd_issue && data_flash_pe_mode
         && command_start_address[18:0] >= DATA_RSV_LO)
        |=> data_area_access_error;
    endproperty
    a_reserved_data_area: assert property (p_reserved_data_area)
        else $error("reserved data address did not set data error");

    property p_config_low;
        @(posedge pclk) disable iff (!presetn)
        (cmd_issue && data_flash_pe_mode && cmd_kind == CMD_CONFIG_PROGRAM
         && command_start_address[18:0] <= SETUP_LOW_HI)
        |=> data_area_access_error;
    endproperty
    a_config_low: assert property (p_config_low)
        else $error("config program low address missed");

    property p_otp_high;
        @(posedge pclk) disable iff (!presetn)
        (cmd_issue && data_flash_pe_mode && cmd_kind == CMD_OTP_SET
         && command_start_address[18:0] >= OTP_RSV_LO)
        |=> data_area_access_error;
    endproperty
    a_otp_high: assert property (p_otp_high)
        else $error("otp set reserved address missed");

    property p_illegal_lock;
        @(posedge pclk) disable iff (!presetn)
        $rose(data_area_access_error)
        |-> illegal_operation_error && command_locked;
    endproperty
    a_illegal_lock: assert property (p_illegal_lock)
        else $error("data error without illegal pulse and lock");

    property p_write_one_kept;
        @(posedge pclk) disable iff (!presetn)
        (status_wr && pwdata[BIT_DATA] && data_area_access_error)
        |=> data_area_access_error;
    endproperty
    a_write_one_kept: assert property (p_write_one_kept)
        else $error("writing one cleared data error");

    property p_corr_clear;
        @(posedge pclk) disable iff (!presetn)
        (corr_clear && !corrected_read) |=> !single_bit_corrected;
    endproperty
    a_corr_clear: assert property (p_corr_clear)
        else $error("correction bit not cleared");

    property p_lock_release;
        @(posedge pclk) disable iff (!presetn)
        (command_locked && lock_release && !lock_set) |=> !command_locked;
    endproperty
    a_lock_release: assert property (p_lock_release)
        else $error("lock not released");

    property p_irq_follows;
        @(posedge pclk) disable iff (!presetn)
        ##1 flash_error_interrupt
            == $past((code_area_access_error && enable_q[BIT_CODE])
                     || (command_locked && enable_q[BIT_LOCK])
                     || (data_area_access_error && enable_q[BIT_DATA])
                     || (single_bit_corrected && enable_q[BIT_CORR]));
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("interrupt does not follow gated flags");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        prdata_q[6:5] == 2'b00 && prdata_q[2:1] == 2'b00
        && enable_q[6:5] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit read nonzero");
endmodule
`default_nettype wire

/* sim/cpu_bus_model.sv */
/*
  CPU side of the register bus: one APB transfer per start request.
  Assumes start is raised for one cycle while the model is idle.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic wr,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    output logic done,
    output logic [31:0] rdata,
    output logic err,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // setup, then access held until pready; released paddr and pwdata get inverted
    // so stale values never look valid to the slave
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            psel <= 1'b0;
            penable <= 1'b0;
            pwrite <= 1'b0;
            paddr <= 32'hFFFF_FFFF;
            pwdata <= 32'hFFFF_FFFF;
            done <= 1'b0;
            rdata <= 32'h0;
            err <= 1'b0;
        end
        else if (psel && penable && pready)
        begin
            rdata <= prdata;
            err <= pslverr;
            done <= 1'b1;
            psel <= 1'b0;
            penable <= 1'b0;
            paddr <= ~paddr;
            pwdata <= ~pwdata;
        end
        else if (psel)
            penable <= 1'b1;
        else if (start)
        begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= addr;
            pwdata <= wdata;
            done <= 1'b0;
        end
        else
            done <= 1'b0;
    end
endmodule
`default_nettype wire

/* sim/test_flash_access_error_monitor.sv */
/*
  Self-checking bench of the flash access error monitor.
  Assumes the CPU bus model beside it; sequencer events come from here.
*/
`timescale 1ns/1ps
`default_nettype none
module test_flash_access_error_monitor;
    import fae_pkg::*;
    logic pclk, presetn, start, wr, done, err, psel, penable, pwrite;
    logic pready, pslverr, mode, ill, lock, irq;
    logic [31:0] addr, wdata, rdata, paddr, pwdata, prdata, csa;
    logic [4:0] evt;
    logic [2:0] corr;
    cmd_kind_t kind;
    int bad_count, n_compared, cyc, ill_n;
    localparam logic [18:0] CORNER [10] = '{19'h0FFFF, 19'h10000,
        19'h7FFFF, 19'h0003F, 19'h00040, 19'h000FF, 19'h00100,
        19'h0009F, 19'h000A0, 19'h00000};
    localparam logic [4:0] EVS [4] = '{5'h01, 5'h02, 5'h04, 5'h10};
    localparam logic [7:0] STS [4] = '{8'h90, 8'h10, 8'h01, 8'h18};

    cpu_bus_model cpu (.pclk(pclk), .presetn(presetn), .start(start),
        .wr(wr), .addr(addr), .wdata(wdata), .done(done), .rdata(rdata),
        .err(err), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    flash_access_error_monitor DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmd_issue(evt[4]), .cmd_kind(kind),
        .data_flash_pe_mode(mode), .command_start_address(csa),
        .code_area_error_detect(evt[0]), .lock_error_detect(evt[1]),
        .corrected_read(evt[2]), .status_clear_start(evt[3]),
        .config_read_corrected(corr[0]),
        .parameter_table_corrected(corr[1]),
        .one_time_area_corrected(corr[2]),
        .illegal_operation_error(ill), .command_locked(lock),
        .flash_error_interrupt(irq));

    // 20 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // hang guard and illegal pulse counter
    always @(posedge pclk)
    begin
        cyc++;
        if (ill === 1'b1)
            ill_n++;
        if (cyc == 20000)
        begin
            bad_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // one transfer; only the hang guard ends the wait
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        start <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge pclk);
        start <= 1'b0;
        while (done !== 1'b1)
        begin
            @(posedge pclk);
            n++;
        end
        // setup, access with no wait state, then the model's done flop
        check(n, 3);
    endtask

    // one-cycle event pulse, then time for flags and interrupt to settle
    task automatic pulse(input logic [4:0] v);
        @(posedge pclk);
        evt <= v;
        @(posedge pclk);
        evt <= 5'h00;
        repeat (3) @(posedge pclk);
    endtask

    // read-one then write-zero, then release lock and correction
    task automatic clean();
        bus(1'b0, STATUS_ADDR, 32'h0);
        bus(1'b1, STATUS_ADDR, 32'h0);
        corr <= 3'b111;
        pulse(5'h08);
        corr <= 3'b000;
        check(lock, 1'b0);
    endtask

    // reserved ranges of the data area, per command kind
    function automatic logic exp_err(logic m, logic [1:0] k,
                                     logic [18:0] a);
        if (!m)
            return 1'b0;
        if (a >= 19'h10000)
            return 1'b1;
        if (k == 2'd1)
            return a <= 19'h3F || a >= 19'h100;
        if (k == 2'd2)
            return a <= 19'h3F || a >= 19'hA0;
        return 1'b0;
    endfunction

    initial
    begin
        int i;
        logic [31:0] v;
        logic [7:0] en;
        logic [1:0] k;
        logic m, x;
        void'($urandom(32'h6321));
        {presetn, start, wr, addr, wdata, evt, corr, mode, csa} = '0;
        kind = CMD_OTHER;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        bus(1'b0, ENABLE_ADDR, 32'h0);
        check(rdata, 32'h99);
        check(err, 1'b0);
        bus(1'b0, STATUS_ADDR, 32'h0);
        check(rdata, 32'h0);
        check({ill, lock, irq}, 3'b000);
        bus(1'b0, 32'hFFA1_0018, 32'h0);
        check(err, 1'b1);
        check(rdata, 32'h0);
        // enable register keeps only its defined bits
        for (i = 0; i < 4; i++)
        begin
            v = $urandom;
            bus(1'b1, ENABLE_ADDR, v);
            bus(1'b0, ENABLE_ADDR, 32'h0);
            check(rdata, v & 32'h99);
        end
        bus(1'b1, ENABLE_ADDR, 32'h99);
        // start address ranges: corners first, then random
        for (i = 0; i < 40; i++)
        begin
            v = $urandom;
            if (i < 10)
                v[18:0] = CORNER[i];
            else
                v[18:0] = v[18:0] & (i[0] ? 19'h1FF : 19'h7FFFF);
            k = 2'($urandom % 3);
            m = ($urandom % 4) != 0;
            x = exp_err(m, k, v[18:0]);
            kind <= cmd_kind_t'(k);
            mode <= m;
            csa <= v;
            ill_n = 0;
            pulse(5'h10);
            bus(1'b0, STATUS_ADDR, 32'h0);
            check(rdata[3], x);
            check(rdata[4], x);
            check(lock, x);
            check(ill_n, x);
            check(irq, x);
            if (x)
                clean();
        end
        // every source against zero, full and random enables
        csa <= 32'h10000;
        for (i = 0; i < 12; i++)
        begin
            en = i < 4 ? 8'h00 : i < 8 ? 8'hFF : 8'($urandom);
            bus(1'b1, ENABLE_ADDR, {24'h0, en});
            mode <= 1'b1;
            kind <= CMD_OTHER;
            pulse(EVS[i % 4]);
            bus(1'b0, STATUS_ADDR, 32'h0);
            check(rdata, STS[i % 4]);
            check(irq, |(STS[i % 4] & en & 8'h99));
            clean();
        end
        // clearing needs a read of one first; writing one does nothing
        bus(1'b1, ENABLE_ADDR, 32'h99);
        pulse(5'h10);
        bus(1'b1, STATUS_ADDR, 32'h0);
        pulse(5'h08);
        bus(1'b0, STATUS_ADDR, 32'h0);
        check(rdata, 32'h18);
        bus(1'b1, STATUS_ADDR, 32'hFF);
        bus(1'b0, STATUS_ADDR, 32'h0);
        check(rdata, 32'h18);
        bus(1'b1, STATUS_ADDR, 32'h0);
        bus(1'b0, STATUS_ADDR, 32'h0);
        check(rdata, 32'h10);
        // correction stays unless all three corrected levels are high
        pulse(5'h04);
        corr <= 3'b101;
        pulse(5'h08);
        check(lock, 1'b0);
        bus(1'b0, STATUS_ADDR, 32'h0);
        check(rdata, 32'h01);
        clean();
        // all three corrected levels high: the correction bit is gone
        bus(1'b0, STATUS_ADDR, 32'h0);
        check(rdata, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
